// file: logic/spc_pkg.sv
// Timing constants for the dual-port RAM write-cycle host controller
package spc_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int CNT_W = 8;

    // Slowest speed grade, so every grade is served
    localparam int CE_TO_END_NS = 90;
    localparam int ADDR_TO_END_NS = 90;
    localparam int ADDR_SETUP_NS = 0;
    localparam int WRITE_PULSE_NS = 55;
    localparam int WRITE_RECOVERY_NS = 0;
    localparam int DATA_TO_END_TIME_NS = 40;
    localparam int DATA_HOLD_NS = 0;
    localparam int WE_TO_HIGHZ_NS = 40;
    localparam int BUSY_ACCESS_NS = 50;

    function automatic int ceil_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    localparam int EW_CYC = ceil_cyc(CE_TO_END_NS);
    localparam int AW_CYC = ceil_cyc(ADDR_TO_END_NS);
    localparam int AS_CYC = ceil_cyc(ADDR_SETUP_NS);
    localparam int WP_CYC = ceil_cyc(WRITE_PULSE_NS);
    localparam int WR_CYC = ceil_cyc(WRITE_RECOVERY_NS);
    localparam int DW_CYC = ceil_cyc(DATA_TO_END_TIME_NS);
    localparam int WZ_CYC = ceil_cyc(WE_TO_HIGHZ_NS);
    localparam int BAA_CYC = ceil_cyc(BUSY_ACCESS_NS);

    // Strobe length without and with the output gate held low
    localparam int PULSE_GATE_HIGH = max2(max2(EW_CYC, AW_CYC), max2(WP_CYC, DW_CYC));
    localparam int PULSE_GATE_LOW = max2(PULSE_GATE_HIGH, WZ_CYC + DW_CYC);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_BUSY_WAIT,
        ST_STROBE,
        ST_RECOVER
    } spc_state_type;

endpackage

// file: logic/spc_cycle_counter.sv
// Saturating cycle counter that restarts on a clear pulse
module spc_cycle_counter #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_clear,
    output logic [WIDTH-1:0] o_count
);
    wire at_max = &o_count;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_clear) begin
            o_count <= '0;
        end else if (!at_max) begin
            o_count <= o_count + 1'b1;
        end
    end
endmodule

// file: logic/spc_write_host.sv
// Host-side write-cycle sequencer for one port of an asynchronous dual-port RAM
////////////////////////////////////////////////////////////////////////////////
module spc_write_host
    import spc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_req,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_data,
    input wire logic i_gate_low,
    input wire logic i_pair_mode,
    input wire logic [DATA_W-1:0] i_io_in,
    output logic o_ready,
    output logic o_done,
    output logic [ADDR_W-1:0] o_addr,
    output logic o_ce_n,
    output logic o_we_n,
    output logic o_oe_n,
    output logic [DATA_W-1:0] o_io_out,
    output logic o_io_oe_n
);
    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    spc_state_type state;
    spc_state_type next_state;
    logic [CNT_W-1:0] cnt;
    logic [DATA_W-1:0] data_hold;
    logic gate_low;
    logic pair_mode;

    // Pin readback, used only to confirm the byte that the host drives
    logic [DATA_W-1:0] io_meta;
    logic [DATA_W-1:0] io_sync;

    wire state_change = (next_state != state);
    wire [CNT_W-1:0] next_idx = state_change ? '0 : cnt + 1'b1;
    wire [CNT_W-1:0] pulse_len = gate_low ? CNT_W'(PULSE_GATE_LOW)
                                          : CNT_W'(PULSE_GATE_HIGH);
    wire [CNT_W-1:0] drive_at = gate_low ? CNT_W'(WZ_CYC) : '0;
    wire setup_done = (cnt == CNT_W'(AS_CYC - 1));
    wire wait_done = (cnt == CNT_W'(BAA_CYC - 1));
    wire strobe_done = (cnt == pulse_len - 1'b1);
    wire recover_done = (cnt == CNT_W'(WR_CYC - 1));
    wire next_strobe = (next_state == ST_STROBE);
    wire next_drive = next_strobe && (next_idx >= drive_at);
    wire take = (state == ST_IDLE) && i_req;
    // Gate choice of the request being taken, so no stale level leaks into set-up
    wire gate_now = take ? i_gate_low : gate_low;

    spc_cycle_counter #(.WIDTH(CNT_W)) u_counter (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_clear(state_change),
        .o_count(cnt)
    );

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (i_req) begin
                    next_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (setup_done) begin
                    next_state = pair_mode ? ST_BUSY_WAIT : ST_STROBE;
                end
            end
            ST_BUSY_WAIT: begin
                if (wait_done) begin
                    next_state = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (strobe_done) begin
                    next_state = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (recover_done) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Address only moves in idle, where both strobes are high
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_addr <= '0;
            data_hold <= '0;
            gate_low <= 1'b0;
            pair_mode <= 1'b0;
        end else if (take) begin
            o_addr <= i_addr;
            data_hold <= i_data;
            gate_low <= i_gate_low;
            pair_mode <= i_pair_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_ce_n <= 1'b1;
            o_we_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_io_out <= '0;
            o_io_oe_n <= 1'b1;
            o_ready <= 1'b0;
            o_done <= 1'b0;
        end else begin
            // Both strobes fall together to keep the RAM outputs quiet
            o_ce_n <= !next_strobe;
            o_we_n <= !next_strobe;
            o_oe_n <= !(gate_now && (next_state != ST_IDLE));
            o_io_out <= data_hold;
            o_io_oe_n <= !next_drive;
            o_ready <= (next_state == ST_IDLE);
            o_done <= (state == ST_RECOVER) && recover_done;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            io_meta <= '0;
            io_sync <= '0;
        end else begin
            io_meta <= i_io_in;
            io_sync <= io_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the pins
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] addr_age;
    logic [CNT_W-1:0] drive_cnt;
    logic [ADDR_W-1:0] addr_prev;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            low_cnt <= '0;
            addr_age <= '0;
            drive_cnt <= '0;
            addr_prev <= '0;
        end else begin
            addr_prev <= o_addr;
            low_cnt <= o_we_n ? '0 : low_cnt + 1'b1;
            drive_cnt <= o_io_oe_n ? '0 : drive_cnt + 1'b1;
            if (o_addr != addr_prev) begin
                addr_age <= '0;
            end else if (!(&addr_age)) begin
                addr_age <= addr_age + 1'b1;
            end
        end
    end

    sequence s_strobe_fall;
        $fell(o_we_n);
    endsequence

    sequence s_strobe_rise;
        $rose(o_we_n);
    endsequence

    property p_overlap;
        @(posedge i_clk) disable iff (i_sys_rst) o_ce_n == o_we_n;
    endproperty
    a_overlap: assert property (p_overlap) else $error("select and strobe split");

    property p_addr_stable;
        @(posedge i_clk) disable iff (i_sys_rst)
            (!o_we_n || !o_ce_n) |-> $stable(o_addr) ##1 $stable(o_addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved in write");

    property p_quiet_outputs;
        @(posedge i_clk) disable iff (i_sys_rst)
            s_strobe_fall |-> $fell(o_ce_n) && (o_io_oe_n || o_oe_n);
    endproperty
    a_quiet_outputs: assert property (p_quiet_outputs) else $error("select late or data early");

    property p_pulse_gate_low;
        @(posedge i_clk) disable iff (i_sys_rst)
            s_strobe_rise and !$past(o_oe_n) |-> low_cnt >= CNT_W'(WZ_CYC + DW_CYC);
    endproperty
    a_pulse_gate_low: assert property (p_pulse_gate_low) else $error("gate-low pulse short");

    property p_pulse_gate_high;
        @(posedge i_clk) disable iff (i_sys_rst) s_strobe_rise |-> low_cnt >= CNT_W'(WP_CYC);
    endproperty
    a_pulse_gate_high: assert property (p_pulse_gate_high) else $error("pulse too short");

    property p_pair_wait;
        @(posedge i_clk) disable iff (i_sys_rst)
            s_strobe_fall and pair_mode |-> addr_age >= CNT_W'(BAA_CYC);
    endproperty
    a_pair_wait: assert property (p_pair_wait) else $error("strobe before busy access");

    property p_no_contention;
        @(posedge i_clk) disable iff (i_sys_rst)
            (!o_io_oe_n && !o_oe_n) |-> !o_we_n && low_cnt >= CNT_W'(WZ_CYC);
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("data driven too early");

    property p_recovery;
        @(posedge i_clk) disable iff (i_sys_rst) s_strobe_rise |=> $stable(o_addr) && o_we_n;
    endproperty
    a_recovery: assert property (p_recovery) else $error("no write recovery");

    property p_select_time;
        @(posedge i_clk) disable iff (i_sys_rst) $rose(o_ce_n) |-> low_cnt >= CNT_W'(EW_CYC);
    endproperty
    a_select_time: assert property (p_select_time) else $error("select low too short");

    property p_addr_time;
        @(posedge i_clk) disable iff (i_sys_rst) s_strobe_rise |-> addr_age >= CNT_W'(AW_CYC);
    endproperty
    a_addr_time: assert property (p_addr_time) else $error("address valid too short");

    property p_data_time;
        @(posedge i_clk) disable iff (i_sys_rst)
            s_strobe_rise |-> !$past(o_io_oe_n) && drive_cnt >= CNT_W'(DW_CYC);
    endproperty
    a_data_time: assert property (p_data_time) else $error("data valid too short");

    property p_bus_readback;
        @(posedge i_clk) disable iff (i_sys_rst)
            (!o_io_oe_n && !$past(o_io_oe_n, 2)) |-> io_sync == o_io_out;
    endproperty
    a_bus_readback: assert property (p_bus_readback) else $error("pins differ from byte");

    property p_bus_released;
        @(posedge i_clk) disable iff (i_sys_rst) s_strobe_rise |-> o_io_oe_n;
    endproperty
    a_bus_released: assert property (p_bus_released) else $error("bus held past end");
endmodule

// file: verif/spc_ram_model.sv
// Behavioural model of one port of the dual-port RAM, write side
module spc_ram_model #(
    parameter int TWZ_NS = 40
) (
    input wire logic [10:0] i_addr,
    input wire logic i_ce_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic [7:0] i_io,
    output logic [7:0] o_io,
    output logic o_drive
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:2047];
    wire wr = !i_ce_n && !i_we_n;
    wire rd = !i_ce_n && !i_oe_n && i_we_n;
    initial o_drive = 1'b0;
    // Byte taken at the end of the overlap, while the host still holds it
    always @(negedge wr) mem[i_addr] <= i_io;
    // Slow release models the worst turn-off time after the strobe falls
    always @(rd) begin
        if (rd) o_drive = 1'b1;
        else o_drive <= #(TWZ_NS) 1'b0;
    end
    assign o_io = mem[i_addr];
endmodule

// file: verif/tb_spc_write_host.sv
// Self-checking bench for the write-cycle host controller
module tb_spc_write_host
    import spc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk, i_sys_rst, i_req, i_gate_low, i_pair_mode;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_data;
    logic o_ready, o_done, o_ce_n, o_we_n, o_oe_n, o_io_oe_n, drive;
    logic [ADDR_W-1:0] o_addr, last_addr;
    logic [DATA_W-1:0] o_io_out, rdata;
    wire [DATA_W-1:0] bus;
    int n_mismatch = 0;
    int n_checks = 0;
    // Floating pins show a changing pattern so stale data never looks valid
    assign #1 bus = !o_io_oe_n ? o_io_out : (drive ? rdata : (8'ha5 ^ {8{i_clk}}));
    spc_write_host uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req),
        .i_addr(i_addr), .i_data(i_data), .i_gate_low(i_gate_low),
        .i_pair_mode(i_pair_mode), .i_io_in(bus), .o_ready(o_ready), .o_done(o_done),
        .o_addr(o_addr), .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n),
        .o_io_out(o_io_out), .o_io_oe_n(o_io_oe_n));
    spc_ram_model #(.TWZ_NS(WE_TO_HIGHZ_NS)) ram (.i_addr(o_addr), .i_ce_n(o_ce_n),
        .i_we_n(o_we_n), .i_oe_n(o_oe_n), .i_io(bus), .o_io(rdata), .o_drive(drive));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic ck(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Both sides driving the pins, or address moving inside a strobe
    always @(posedge i_clk) begin
        if (!i_sys_rst) begin
            if (!o_io_oe_n && drive) ck(1'b0, "bus contention");
            if (!o_ce_n && !o_we_n && o_addr !== last_addr) ck(1'b0, "addr moved");
        end
        last_addr <= o_addr;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One write; a stray request can be raised mid-cycle to test refusal
    task automatic do_write(input logic [10:0] a, input logic [7:0] d, input logic g,
                            input logic p, input logic stray);
        int n;
        int low;
        int exp;
        n = 0;
        low = 0;
        exp = AS_CYC + WR_CYC + (g ? PULSE_GATE_LOW : PULSE_GATE_HIGH) + (p ? BAA_CYC : 0);
        i_addr = a;
        i_data = d;
        i_gate_low = g;
        i_pair_mode = p;
        i_req = 1'b1;
        @(posedge i_clk);
        #1;
        i_req = 1'b0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
            if (stray) i_req = (n > 3 && n < 8);
            if (stray) i_addr = 11'h000;
            if (!o_ce_n && !o_we_n) low++;
            ck(o_ce_n === o_we_n, "select apart from strobe");
            if (!o_we_n) ck(o_oe_n === !g, "output gate level");
            if (!o_done) ck(o_ready === 1'b0, "ready while busy");
        end while (o_done !== 1'b1 && n < 40);
        ck(n == exp, "done latency");
        ck(low == (g ? PULSE_GATE_LOW : PULSE_GATE_HIGH), "strobe width");
        ck(o_ready === 1'b1 && o_ce_n === 1'b1 && o_io_oe_n === 1'b1, "end state");
        ck(ram.mem[a] === d, "byte not stored");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        ck(o_ce_n === 1'b1 && o_we_n === 1'b1 && o_oe_n === 1'b1, "strobes in reset");
        ck(o_io_oe_n === 1'b1 && o_ready === 1'b0 && o_done === 1'b0, "flags in reset");
        i_sys_rst = 1'b0;
        @(posedge i_clk);
        #1;
        ck(o_ready === 1'b1, "ready after reset");
    endtask
    task automatic t_modes();
        do_write(11'h123, 8'h5a, 1'b0, 1'b0, 1'b0);
        do_write(11'h124, 8'ha5, 1'b1, 1'b0, 1'b0);
        do_write(11'h125, 8'h0f, 1'b0, 1'b1, 1'b0);
        do_write(11'h126, 8'hf0, 1'b1, 1'b1, 1'b0);
    endtask
    task automatic t_back_to_back();
        do_write(11'h7ff, 8'hc3, 1'b0, 1'b0, 1'b0);
        do_write(11'h000, 8'h3c, 1'b1, 1'b0, 1'b0);
    endtask
    task automatic t_refused();
        do_write(11'h7ff, 8'h55, 1'b0, 1'b0, 1'b1);
        // A queued stray request would start within this span
        repeat (2 * (AS_CYC + PULSE_GATE_LOW + WR_CYC)) begin
            @(posedge i_clk);
            #1;
            ck(o_ce_n === 1'b1 && o_ready === 1'b1, "busy request started");
        end
        ck(ram.mem[11'h000] === 8'h3c, "busy request written");
    endtask
    initial begin
        i_sys_rst = 1'b1;
        i_req = 1'b0;
        i_addr = '0;
        i_data = '0;
        i_gate_low = 1'b0;
        i_pair_mode = 1'b0;
        repeat (20) @(posedge i_clk);
        #1;
        t_reset();
        t_modes();
        t_back_to_back();
        t_refused();
        complete_run();
    end
    initial begin
        #20000;
        n_mismatch++;
        complete_run();
    end
endmodule
